// file: rtl/cmd_filter_pkg.sv
// Notes on behaviour
// - Address filtering is off after reset; unprefixed commands are accepted.
// - With filtering on, only commands prefixed with the stored address or an asterisk are acted on.
// - An asterisk prefix is a broadcast executed regardless of stored address.
// - Address command with one digit 0..9 stores that digit as address.
// - Address command prefixed with current address replaces the stored address.
// - In RS-232 mode, address command with asterisk argument clears the address and filtering.
// - Transmit output stays inactive on a shared line except while replying.
// - Before a reply the transmit output is driven low for 2 ms.
// - Offset setting accepts 1 up to 96 minus position count, else rejected.
// - Move targets accepted only from offset to offset plus count minus one.
// - Offset resets to 1.
// - In RS-485 mode a command must start with a slash or is discarded.
// - RS-485 commands carry an address digit or letter, compared ignoring case.
// - In RS-485 mode with no stored address, the address is taken as Z.
// - Stored address survives switching between RS-232 and RS-485 modes.
// - In RS-485 mode the address may change but never be cleared.
// - With filtering on, transmit line is released except during a reply.
// - Carriage return ends a command; line feeds are dropped.
package cmd_filter_pkg;
  localparam logic [7:0] CH_CR    = 8'h0d;
  localparam logic [7:0] CH_LF    = 8'h0a;
  localparam logic [7:0] CH_SLASH = 8'h2f;
  localparam logic [7:0] CH_STAR  = 8'h2a;
  localparam logic [7:0] CH_Z     = 8'h5a;
  localparam logic [7:0] CH_I     = 8'h49;
  localparam logic [7:0] CH_D     = 8'h44;
  localparam logic [7:0] CH_S     = 8'h53;
  localparam logic [7:0] CH_O     = 8'h4f;
  localparam logic [7:0] CH_G     = 8'h47;

  localparam int         LINE_DEPTH      = 8;
  localparam logic [6:0] OFFSET_RESET    = 7'h01;
  localparam logic [6:0] OFFSET_MIN      = 7'h01;
  localparam logic [7:0] POS_LIMIT       = 8'h60;
  localparam logic [6:0] POS_COUNT_RESET = 7'h0a;

  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_OFFSET = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_TARGET = 4'hc;

  localparam int ST_ADDR_LSB  = 0;
  localparam int ST_ADDR_SET  = 8;
  localparam int ST_RS485     = 9;
  localparam int ST_FILTER    = 10;
  localparam int ST_TX_ACTIVE = 11;
  localparam int ST_OVERRUN   = 12;

  localparam int FLUSH_TIME_US = 2000;
  localparam int CLK_FREQ_MHZ  = 100;
  localparam int FLUSH_CYCLES  = FLUSH_TIME_US * CLK_FREQ_MHZ;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_FLUSH = 2'b01,
    TX_SEND  = 2'b11
  } tx_state_t;

  function automatic logic is_digit(input logic [7:0] c);
    return (c >= 8'h30) && (c <= 8'h39);
  endfunction : is_digit

  function automatic logic [7:0] upcase(input logic [7:0] c);
    return ((c >= 8'h61) && (c <= 8'h7a)) ? (c - 8'h20) : c;
  endfunction : upcase

  function automatic logic is_letter(input logic [7:0] c);
    logic [7:0] u;
    u = upcase(c);
    return (u >= 8'h41) && (u <= 8'h5a);
  endfunction : is_letter

  function automatic logic [6:0] digit_val(input logic [7:0] c);
    logic [7:0] v;
    v = c - 8'h30;
    return v[6:0];
  endfunction : digit_val
endpackage : cmd_filter_pkg

// file: rtl/addressed_cmd_filter.sv
// The strobed register port and the register offsets were decided locally.
module addressed_cmd_filter #(
  parameter int unsigned FLUSH_CYCLES = cmd_filter_pkg::FLUSH_CYCLES
) (
  input  wire logic        mclk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        rs485_mode_in,
  input  wire logic [7:0]  rx_byte_in,
  input  wire logic        rx_valid_in,
  input  wire logic        reply_req_in,
  input  wire logic        reply_bit_in,
  input  wire logic        reply_done_in,
  input  wire logic [3:0]  bus_addr_in,
  input  wire logic [31:0] bus_wdata_in,
  input  wire logic        bus_wr_in,
  input  wire logic        bus_rd_in,
  output logic      [31:0] bus_rdata_out,
  output logic             tx_out,
  output logic             tx_oe_n_out,
  output logic             reply_grant_out,
  output logic             cmd_valid_out,
  output logic      [15:0] cmd_code_out,
  output logic             cmd_broadcast_out,
  output logic             move_valid_out,
  output logic      [6:0]  move_target_out
);

  logic                  mode_meta_q;
  logic                  rs485_q;
  logic [7:0]            line_q [cmd_filter_pkg::LINE_DEPTH];
  logic [3:0]            len_q;
  logic                  overrun_q;
  logic [7:0]            addr_q;
  logic                  addr_set_q;
  logic [6:0]            offset_q;
  logic [6:0]            npos_q;
  logic                  answer_ok_q;
  cmd_filter_pkg::tx_state_t tx_state_q;
  logic [31:0]           flush_cnt_q;

  // Decode results, valid in the cycle a carriage return arrives
  logic                  line_end;
  logic                  accept;
  logic                  bcast;
  logic                  addr_load;
  logic                  addr_clear;
  logic [7:0]            addr_new;
  logic                  so_ok;
  logic                  go_ok;
  logic                  generic;
  logic [6:0]            num_val;
  logic [15:0]           code;

  function automatic logic [7:0] char_at(input logic [3:0] i);
    logic [2:0] j;
    j = i[2:0];
    return (i < len_q) ? line_q[j] : 8'h00;
  endfunction : char_at

  // Mode pin is static but asynchronous to the clock
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mode_meta_q <= 1'b0;
      rs485_q     <= 1'b0;
    end else begin
      mode_meta_q <= rs485_mode_in;
      rs485_q     <= mode_meta_q;
    end
  end

  assign line_end = rx_valid_in && (rx_byte_in == cmd_filter_pkg::CH_CR);

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      len_q     <= 4'h0;
      overrun_q <= 1'b0;
      for (int i = 0; i < cmd_filter_pkg::LINE_DEPTH; i++) begin
        line_q[i] <= 8'h00;
      end
    end else if (line_end) begin
      len_q     <= 4'h0;
      overrun_q <= 1'b0;
    end else if (rx_valid_in && (rx_byte_in != cmd_filter_pkg::CH_LF)) begin
      if (len_q == 4'(cmd_filter_pkg::LINE_DEPTH)) begin
        overrun_q <= 1'b1;
      end else begin
        line_q[len_q[2:0]] <= rx_byte_in;
        len_q              <= len_q + 4'h1;
      end
    end
  end

  always_comb begin
    logic [3:0] p;
    logic [3:0] b;
    logic [3:0] nargs;
    logic [7:0] c0;
    logic [7:0] a0;
    logic [7:0] a1;
    logic [7:0] eff_addr;
    logic [7:0] win_hi;
    logic       prefixed;
    logic       match;
    logic       num_ok;
    match    = 1'b0;
    p        = rs485_q ? 4'h1 : 4'h0;
    c0       = char_at(p);
    bcast    = (c0 == cmd_filter_pkg::CH_STAR);
    eff_addr = addr_set_q ? addr_q : cmd_filter_pkg::CH_Z;
    prefixed = !bcast && (rs485_q ? (cmd_filter_pkg::is_digit(c0) ||
                                     cmd_filter_pkg::is_letter(c0))
                                  : cmd_filter_pkg::is_digit(c0));
    if (bcast) begin
      match = 1'b1;
    end else if (prefixed) begin
      match = (cmd_filter_pkg::upcase(c0) == eff_addr);
    end else begin
      match = !rs485_q && !addr_set_q;
    end
    b        = p + {3'h0, (bcast || prefixed)};
    code     = {cmd_filter_pkg::upcase(char_at(b)),
                cmd_filter_pkg::upcase(char_at(b + 4'h1))};
    a0       = char_at(b + 4'h2);
    a1       = char_at(b + 4'h3);
    nargs    = (len_q >= b + 4'h2) ? (len_q - b - 4'h2) : 4'h0;
    accept   = line_end && !overrun_q && match && (len_q >= b + 4'h2) &&
               (!rs485_q || (char_at(4'h0) == cmd_filter_pkg::CH_SLASH));
    num_ok   = ((nargs == 4'h1) && cmd_filter_pkg::is_digit(a0)) ||
               ((nargs == 4'h2) && cmd_filter_pkg::is_digit(a0) &&
                cmd_filter_pkg::is_digit(a1));
    num_val  = (nargs == 4'h1) ? cmd_filter_pkg::digit_val(a0)
             : 7'(cmd_filter_pkg::digit_val(a0) * 7'd10 + cmd_filter_pkg::digit_val(a1));
    addr_load  = 1'b0;
    addr_clear = 1'b0;
    addr_new   = cmd_filter_pkg::upcase(a0);
    so_ok    = 1'b0;
    go_ok    = 1'b0;
    generic  = 1'b0;
    win_hi   = {1'b0, offset_q} + {1'b0, npos_q} - 8'h01;
    if (code == {cmd_filter_pkg::CH_I, cmd_filter_pkg::CH_D} && nargs == 4'h1) begin
      if (a0 == cmd_filter_pkg::CH_STAR) begin
        addr_clear = accept && !rs485_q;
      end else if (cmd_filter_pkg::is_digit(a0) ||
                   (rs485_q && cmd_filter_pkg::is_letter(a0))) begin
        addr_load = accept;
      end
    end else if (code == {cmd_filter_pkg::CH_S, cmd_filter_pkg::CH_O} && nargs != 4'h0) begin
      so_ok = accept && num_ok && (num_val >= cmd_filter_pkg::OFFSET_MIN) &&
              ({1'b0, num_val} <= cmd_filter_pkg::POS_LIMIT - {1'b0, npos_q});
    end else if (code == {cmd_filter_pkg::CH_G, cmd_filter_pkg::CH_O} && nargs != 4'h0) begin
      go_ok = accept && num_ok && (num_val >= offset_q) && ({1'b0, num_val} <= win_hi);
    end else begin
      generic = accept;
    end
  end

  // Stored address, untouched by mode changes
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      addr_q     <= 8'h00;
      addr_set_q <= 1'b0;
    end else if (addr_load) begin
      addr_q     <= addr_new;
      addr_set_q <= 1'b1;
    end else if (addr_clear) begin
      addr_q     <= 8'h00;
      addr_set_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      offset_q <= cmd_filter_pkg::OFFSET_RESET;
    end else if (so_ok) begin
      offset_q <= num_val;
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      npos_q <= cmd_filter_pkg::POS_COUNT_RESET;
    end else if (bus_wr_in && (bus_addr_in == cmd_filter_pkg::REG_CTRL)) begin
      npos_q <= bus_wdata_in[6:0];
    end
  end

  // Command outputs to the actuator core
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cmd_valid_out     <= 1'b0;
      cmd_code_out      <= 16'h0000;
      cmd_broadcast_out <= 1'b0;
      move_valid_out    <= 1'b0;
      move_target_out   <= 7'h00;
    end else begin
      cmd_valid_out  <= generic;
      move_valid_out <= go_ok;
      if (generic || go_ok) begin
        cmd_code_out      <= code;
        cmd_broadcast_out <= bcast;
      end
      if (go_ok) begin
        move_target_out <= num_val;
      end
    end
  end

  // A reply is allowed only after an accepted command
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      answer_ok_q <= 1'b0;
    end else if (line_end) begin
      answer_ok_q <= accept;
    end else if (reply_req_in && (tx_state_q == cmd_filter_pkg::TX_IDLE)) begin
      answer_ok_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tx_state_q  <= cmd_filter_pkg::TX_IDLE;
      flush_cnt_q <= 32'h0000_0000;
    end else begin
      case (tx_state_q)
        cmd_filter_pkg::TX_IDLE: begin
          if (reply_req_in && answer_ok_q) begin
            tx_state_q  <= cmd_filter_pkg::TX_FLUSH;
            flush_cnt_q <= 32'h0000_0000;
          end
        end
        cmd_filter_pkg::TX_FLUSH: begin
          if (flush_cnt_q == 32'(FLUSH_CYCLES - 1)) begin
            tx_state_q <= cmd_filter_pkg::TX_SEND;
          end else begin
            flush_cnt_q <= flush_cnt_q + 32'h1;
          end
        end
        cmd_filter_pkg::TX_SEND: begin
          if (reply_done_in) begin
            tx_state_q <= cmd_filter_pkg::TX_IDLE;
          end
        end
        default: tx_state_q <= cmd_filter_pkg::TX_IDLE;
      endcase
    end
  end

  // Line pins: released on a shared line unless replying
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tx_out          <= 1'b1;
      tx_oe_n_out     <= 1'b1;
      reply_grant_out <= 1'b0;
    end else begin
      case (tx_state_q)
        cmd_filter_pkg::TX_FLUSH: begin
          tx_out          <= 1'b0;
          tx_oe_n_out     <= 1'b0;
          reply_grant_out <= 1'b0;
        end
        cmd_filter_pkg::TX_SEND: begin
          // End of reply returns the line to idle at once
          if (reply_done_in) begin
            tx_out          <= 1'b1;
            tx_oe_n_out     <= rs485_q || addr_set_q;
            reply_grant_out <= 1'b0;
          end else begin
            tx_out          <= reply_bit_in;
            tx_oe_n_out     <= 1'b0;
            reply_grant_out <= 1'b1;
          end
        end
        default: begin
          tx_out          <= 1'b1;
          tx_oe_n_out     <= rs485_q || addr_set_q;
          reply_grant_out <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bus_rdata_out <= 32'h0000_0000;
    end else if (bus_rd_in) begin
      case (bus_addr_in)
        cmd_filter_pkg::REG_CTRL:   bus_rdata_out <= {25'h0, npos_q};
        cmd_filter_pkg::REG_OFFSET: bus_rdata_out <= {25'h0, offset_q};
        cmd_filter_pkg::REG_TARGET: bus_rdata_out <= {25'h0, move_target_out};
        cmd_filter_pkg::REG_STATUS: begin
          bus_rdata_out <= 32'h0000_0000;
          bus_rdata_out[cmd_filter_pkg::ST_ADDR_LSB +: 8] <= addr_q;
          bus_rdata_out[cmd_filter_pkg::ST_ADDR_SET]      <= addr_set_q;
          bus_rdata_out[cmd_filter_pkg::ST_RS485]         <= rs485_q;
          bus_rdata_out[cmd_filter_pkg::ST_FILTER]        <= addr_set_q || rs485_q;
          bus_rdata_out[cmd_filter_pkg::ST_TX_ACTIVE]     <=
            (tx_state_q != cmd_filter_pkg::TX_IDLE);
          bus_rdata_out[cmd_filter_pkg::ST_OVERRUN]       <= overrun_q;
        end
        default: bus_rdata_out <= 32'h0000_0000;
      endcase
    end else begin
      bus_rdata_out <= 32'h0000_0000;
    end
  end

endmodule : addressed_cmd_filter

// file: testbench/cmd_filter_properties.sv
module cmd_filter_properties #(
  parameter int unsigned FLUSH_CYCLES = 20
) (
  input wire logic        mclk_in,
  input wire logic        sys_rst_in,
  input wire logic [7:0]  rx_byte_in,
  input wire logic        rx_valid_in,
  input wire logic        reply_bit_in,
  input wire logic        reply_done_in,
  input wire logic        bus_rd_in,
  input wire logic [31:0] bus_rdata_out,
  input wire logic        tx_out,
  input wire logic        tx_oe_n_out,
  input wire logic        reply_grant_out,
  input wire logic        cmd_valid_out,
  input wire logic        move_valid_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] flush_cnt_q;

  // Length of the current low stretch before a reply is granted
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      flush_cnt_q <= 32'h0;
    end else if (!tx_out && !reply_grant_out) begin
      flush_cnt_q <= flush_cnt_q + 32'h1;
    end else begin
      flush_cnt_q <= 32'h0;
    end
  end

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (sys_rst_in);

  AST_TX_LOW_DRIVEN: assert property (!tx_out |-> !tx_oe_n_out)
    else $error("line low while released");
  AST_GRANT_DRIVES: assert property (reply_grant_out |-> !tx_oe_n_out)
    else $error("reply sent on released line");
  AST_FLUSH_LEN: assert property ($rose(reply_grant_out) |-> flush_cnt_q >= FLUSH_CYCLES)
    else $error("flush too short");
  AST_FLUSH_HOLD: assert property ($fell(tx_out) && !reply_grant_out |=> !tx_out [*8])
    else $error("flush broken early");
  AST_GRANT_END: assert property (reply_grant_out && reply_done_in |=> !reply_grant_out && tx_out)
    else $error("line not idle after reply");
  AST_TX_FOLLOWS: assert property (
    reply_grant_out && $past(reply_grant_out) |-> tx_out == $past(reply_bit_in))
    else $error("reply bit not passed");
  AST_CMD_ON_CR: assert property (
    cmd_valid_out |-> $past(rx_valid_in) && $past(rx_byte_in) == cmd_filter_pkg::CH_CR)
    else $error("command without carriage return");
  AST_MOVE_ALONE: assert property (move_valid_out |-> !cmd_valid_out && $past(rx_valid_in))
    else $error("move with command pulse");
  AST_LF_DROP: assert property (
    rx_valid_in && rx_byte_in == cmd_filter_pkg::CH_LF |=> !cmd_valid_out && !move_valid_out)
    else $error("line feed ended a command");
  AST_RDATA_IDLE: assert property (!$past(bus_rd_in) |-> bus_rdata_out == 32'h0)
    else $error("read data outside read slot");
endmodule : cmd_filter_properties

// file: testbench/serial_host_model.sv
module serial_host_model (
  input  wire logic       mclk_in,
  input  wire logic       tx_in,
  input  wire logic       tx_oe_n_in,
  output logic      [7:0] rx_byte_out,
  output logic            rx_valid_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic line_level;
  int   junk_edges = 0;

  // Released line is pulled to idle by the bias network
  assign line_level = tx_oe_n_in ? 1'b1 : tx_in;
  // A flush low before a reply is only counted, never a fault
  always @(negedge line_level) junk_edges++;

  initial begin
    rx_byte_out  = 8'h00;
    rx_valid_out = 1'b0;
  end

  // Strings carry their own slash and address prefix
  task automatic send_line(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge mclk_in);
      rx_byte_out  <= s[i];
      rx_valid_out <= 1'b1;
    end
    @(posedge mclk_in);
    rx_byte_out <= cmd_filter_pkg::CH_CR;
    @(posedge mclk_in);
    rx_valid_out <= 1'b0;
    rx_byte_out  <= ~cmd_filter_pkg::CH_CR;
    #1;
  endtask : send_line
endmodule : serial_host_model

// file: testbench/test_actuator_addressed_command_filter.sv
module test_actuator_addressed_command_filter;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int FLS = 20;
  logic        mclk_in, sys_rst_in, rs485_mode_in, reply_req_in, reply_bit_in;
  logic        reply_done_in, bus_wr_in, bus_rd_in, rx_valid, tx_out, tx_oe_n_out;
  logic        reply_grant_out, cmd_valid_out, cmd_broadcast_out, move_valid_out;
  logic [3:0]  bus_addr_in;
  logic [7:0]  rx_byte;
  logic [15:0] cmd_code_out;
  logic [6:0]  move_target_out;
  logic [31:0] bus_wdata_in, bus_rdata_out, seed, rdat;
  int          num_errors = 0, comparisons = 0, addr_m, off_m, cnt_m, n;
  int          n_list[3] = '{0, 81, 80};
  int          t_list[4] = '{79, 80, 95, 96};

  addressed_cmd_filter #(.FLUSH_CYCLES(FLS)) DUT (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .rs485_mode_in(rs485_mode_in),
    .rx_byte_in(rx_byte), .rx_valid_in(rx_valid), .reply_req_in(reply_req_in),
    .reply_bit_in(reply_bit_in), .reply_done_in(reply_done_in), .bus_addr_in(bus_addr_in),
    .bus_wdata_in(bus_wdata_in), .bus_wr_in(bus_wr_in), .bus_rd_in(bus_rd_in),
    .bus_rdata_out(bus_rdata_out), .tx_out(tx_out), .tx_oe_n_out(tx_oe_n_out),
    .reply_grant_out(reply_grant_out), .cmd_valid_out(cmd_valid_out),
    .cmd_code_out(cmd_code_out), .cmd_broadcast_out(cmd_broadcast_out),
    .move_valid_out(move_valid_out), .move_target_out(move_target_out));
  serial_host_model u_host (.mclk_in(mclk_in), .tx_in(tx_out), .tx_oe_n_in(tx_oe_n_out),
    .rx_byte_out(rx_byte), .rx_valid_out(rx_valid));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic rd(input logic [3:0] a);
    @(posedge mclk_in);
    bus_addr_in <= a;
    bus_rd_in   <= 1'b1;
    @(posedge mclk_in);
    bus_rd_in <= 1'b0;
    #1;
    rdat = bus_rdata_out;
  endtask : rd

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    bus_addr_in  <= a;
    bus_wdata_in <= d;
    bus_wr_in    <= 1'b1;
    @(posedge mclk_in);
    bus_wr_in <= 1'b0;
  endtask : wr

  task automatic cmd(input string s, input logic c, input logic m, input int t);
    u_host.send_line(s);
    chk(32'(cmd_valid_out), 32'(c));
    chk(32'(move_valid_out), 32'(m));
    if (m) chk(32'(move_target_out), 32'(t));
  endtask : cmd

  task automatic status();
    rd(cmd_filter_pkg::REG_STATUS);
    chk(rdat & 32'h5ff, (addr_m < 0) ? 32'h0 : 32'h500 | 32'(addr_m));
  endtask : status

  task automatic go(input int t);
    cmd($sformatf("GO%0d", t), 1'b0, (t >= off_m) && (t <= off_m + cnt_m - 1), t);
  endtask : go

  task automatic so(input int v);
    cmd($sformatf("SO%0d", v), 1'b0, 1'b0, 0);
    if (v >= 1 && v <= 96 - cnt_m) off_m = v;
    rd(cmd_filter_pkg::REG_OFFSET);
    chk(rdat, 32'(off_m));
  endtask : so

  task automatic req_reply();
    @(posedge mclk_in);
    reply_req_in <= 1'b1;
    @(posedge mclk_in);
    reply_req_in <= 1'b0;
  endtask : req_reply

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  initial begin
    repeat (20000) @(posedge mclk_in);
    num_errors++;
    results();
  end

  initial begin
    {rs485_mode_in, reply_req_in, reply_bit_in, reply_done_in, bus_wr_in, bus_rd_in} = 6'h00;
    bus_addr_in  = 4'h0;
    bus_wdata_in = 32'h0;
    sys_rst_in   = 1'b1;
    seed         = 32'h48;
    addr_m       = -1;
    off_m        = 1;
    cnt_m        = 10;
    repeat (16) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    rd(cmd_filter_pkg::REG_OFFSET);
    chk(rdat, 32'h1);
    rd(4'h2);
    chk(rdat, 32'h0);
    status();
    cmd("V\nR", 1'b1, 1'b0, 0);
    chk(32'(cmd_code_out), 32'h5652);
    req_reply();
    n = 0;
    while (reply_grant_out !== 1'b1 && n < 100) begin
      @(posedge mclk_in);
      seed = xs(seed);
      reply_bit_in <= seed[0];
      #1;
      n++;
    end
    chk(32'(n >= FLS && n <= FLS + 2), 32'h1);
    chk(32'(u_host.junk_edges > 0), 32'h1);
    repeat (6) @(posedge mclk_in) reply_bit_in <= ~reply_bit_in;
    reply_done_in <= 1'b1;
    @(posedge mclk_in) reply_done_in <= 1'b0;
    #1;
    chk(32'({reply_grant_out, tx_out}), 32'h1);
    $display("test done: defaults and reply");
    cmd("9VR", 1'b0, 1'b0, 0);
    req_reply();
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk_in);
      #1;
      chk(32'(tx_out), 32'h1);
    end
    cmd("ID3", 1'b0, 1'b0, 0);
    addr_m = 8'h33;
    status();
    chk(32'(tx_oe_n_out), 32'h1);
    cmd("VR", 1'b0, 1'b0, 0);
    cmd("3VR", 1'b1, 1'b0, 0);
    cmd("*VR", 1'b1, 1'b0, 0);
    chk(32'(cmd_broadcast_out), 32'h1);
    cmd("3ID5", 1'b0, 1'b0, 0);
    addr_m = 8'h35;
    status();
    cmd("5ID*", 1'b0, 1'b0, 0);
    addr_m = -1;
    status();
    $display("test done: addressing");
    wr(cmd_filter_pkg::REG_CTRL, 32'h10);
    cnt_m = 16;
    rd(cmd_filter_pkg::REG_CTRL);
    chk(rdat, 32'(cnt_m));
    wr(cmd_filter_pkg::REG_OFFSET, 32'h7);
    foreach (n_list[i]) so(n_list[i]);
    foreach (t_list[i]) go(t_list[i]);
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      go(70 + int'(seed % 30));
    end
    $display("test done: offset window");
    @(posedge mclk_in) rs485_mode_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    cmd("/ZVR", 1'b1, 1'b0, 0);
    cmd("ZZVR", 1'b0, 1'b0, 0);
    cmd("/zVR", 1'b1, 1'b0, 0);
    cmd("/ZID7", 1'b0, 1'b0, 0);
    cmd("/7ID*", 1'b0, 1'b0, 0);
    cmd("/7VR", 1'b1, 1'b0, 0);
    rd(cmd_filter_pkg::REG_STATUS);
    chk(rdat & 32'h600, 32'h600);
    @(posedge mclk_in) rs485_mode_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    addr_m = 8'h37;
    status();
    cmd("7VR", 1'b1, 1'b0, 0);
    $display("test done: shared line mode");
    results();
  end
endmodule : test_actuator_addressed_command_filter

bind addressed_cmd_filter cmd_filter_properties #(.FLUSH_CYCLES(FLUSH_CYCLES)) u_props (
  .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .rx_byte_in(rx_byte_in),
  .rx_valid_in(rx_valid_in), .reply_bit_in(reply_bit_in), .reply_done_in(reply_done_in),
  .bus_rd_in(bus_rd_in), .bus_rdata_out(bus_rdata_out), .tx_out(tx_out),
  .tx_oe_n_out(tx_oe_n_out), .reply_grant_out(reply_grant_out),
  .cmd_valid_out(cmd_valid_out), .move_valid_out(move_valid_out));
